// ==== board_pins.sv ====
module board_pins
  import pin_port_pkg::*;
(
  input wire logic [NUM_PINS-1:0] pin_out, pin_oe, board_val,
  output logic [NUM_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins read back; undriven ones follow the board
  assign pin_in = (pin_out & pin_oe) | (board_val & ~pin_oe);
endmodule

// ==== general_purpose_pin_port.sv ====
// Behaviour
// RULE1 - Eight pins, each input or output, controlled by one port register.
// RULE2 - Bit 8 selects whether low byte means pin directions or pin data.
// RULE3 - Select set: writing low byte sets direction, 1 output, 0 input.
// RULE4 - Hardware reset makes all pins inputs, nothing driven.
// RULE5 - Select clear: writing low byte sets levels driven on output pins.
// RULE6 - Select clear: reading low byte gives input levels and driven output values.
// RULE7 - Select set: read returns directions; inputs synchronised before reading.
module general_purpose_pin_port
  import pin_port_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe
);
  typedef struct packed {
    logic port_access_select;
    logic [NUM_PINS-1:0] dir;
    logic [NUM_PINS-1:0] out_val;
    logic wr_pend;
    logic [31:0] rdata;
  } port_s;

  port_s st_r;
  port_s st_nxt;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_direction_or_value;
  logic addr_hit;
  logic rd_req;
  logic wr_req;

  // Input pins cross into hclk before software sees them
  pin_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(pin_in),
    .level(pin_level)
  );

  // Address phase decode; only whole-word transfers hit the register
  assign addr_hit = (haddr[7:2] == PIN_PORT_REGISTER_OFFSET[7:2]) && (hsize == HSIZE_WORD);
  assign rd_req = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)
                  && !hwrite;
  assign wr_req = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)
                  && hwrite && addr_hit;

  // Data view of the low byte: inputs from pins, outputs from driven value
  always_comb begin
    pin_direction_or_value = (pin_level & ~st_r.dir) | (st_r.out_val & st_r.dir); // RULE6
  end

  // Register state update and read capture
  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_pend = wr_req;
    if (st_r.wr_pend) begin
      st_nxt.port_access_select = hwdata[SELECT_BIT]; // RULE2
      if (st_r.port_access_select) begin
        st_nxt.dir = hwdata[NUM_PINS-1:0]; // RULE3
      end else begin
        st_nxt.out_val = hwdata[NUM_PINS-1:0]; // RULE5
      end
    end
    if (rd_req) begin
      if (!addr_hit) begin
        st_nxt.rdata = 32'h0000_0000; // Unmapped reads give zero
      end else if (st_r.port_access_select) begin
        st_nxt.rdata = {UPPER_READ, 1'b1, st_r.dir}; // RULE7
      end else begin
        st_nxt.rdata = {UPPER_READ, 1'b0, pin_direction_or_value}; // RULE6
      end
    end
  end

  // Reset leaves every pin an input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.port_access_select <= SELECT_RESET;
      st_r.dir <= DIR_RESET; // RULE4
      st_r.out_val <= OUT_RESET;
      st_r.wr_pend <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Zero wait states; select read back is the bit written last, so a
  // write that flips select applies its low byte under the old mode
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = st_r.rdata;
  assign pin_oe = st_r.dir; // RULE1
  assign pin_out = st_r.out_val & st_r.dir;
endmodule

// ==== general_purpose_pin_port_test.sv ====
module general_purpose_pin_port_test
  import pin_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, s = 98706;
  logic [1:0] htrans = 0, hresp;
  logic [2:0] hsize = HSIZE_WORD;
  logic [7:0] pin_in, pin_out, pin_oe, bv = 0, d, v;
  wire hready;
  int n_fail = 0, cmp_count = 0;
  general_purpose_pin_port dut (.hreadyout(hready), .*);
  board_pins brd (.board_val(bv), .*);
  initial forever #4 hclk = ~hclk;
  // Hang guard, well past the run length
  initial begin #20000; n_fail++; print_verdict(); end
  function automatic logic [31:0] rnd();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s;
  endfunction
  // Outputs read their value, inputs the board
  function automatic logic [31:0] ex(logic m);
    return {UPPER_READ, m, m ? d : (v & d) | (bv & ~d)};
  endfunction
  task automatic chk(string n, logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin n_fail++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
  endtask
  // Address held to first ready, data taken at second
  task automatic xf(logic w, logic [7:0] a, logic [31:0] t);
    hsel <= 1; htrans <= HTRANS_NONSEQ; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 0; htrans <= 0; hwdata <= t;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Select, direction, read back, value, then read back data and unmapped address
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk("oe", 0, pin_oe);
    chk("resp", {30'h0, HRESP_OKAY}, {30'h0, hresp});
    for (int i = 0; i < 4; i++) begin
      q = rnd(); d = q[7:0]; v = q[15:8]; bv <= q[23:16];
      xf(1, 8'h60, 32'h100); xf(1, 8'h60, {24'h1, d}); xf(0, 8'h60, 0);
      chk("dir", ex(1), q);
      xf(1, 8'h60, {24'h0, d}); xf(1, 8'h60, {24'h0, v}); repeat (6) @(posedge hclk);
      chk("pins", {d, v & d}, {pin_oe, pin_out});
      xf(0, 8'h60, 0);
      chk("data", ex(0), q);
      xf(0, 8'h64, 0);
      chk("miss", 0, q);
    end
    print_verdict();
  end
endmodule

// ==== pin_port_assertions.sv ====
module pin_port_checker
  import pin_port_pkg::*;
(
  input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout,
  input wire logic [31:0] haddr, hrdata,
  input wire logic [1:0] htrans, hresp,
  input wire logic [NUM_PINS-1:0] pin_out, pin_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read taken at its address edge
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire hit = haddr[7:2] == 6'h18;
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("wait");
  property p_ok; hresp == HRESP_OKAY; endproperty
  a_ok: assert property (p_ok) else $error("resp");
  property p_rst; $rose(hresetn) |-> pin_oe == DIR_RESET; endproperty
  a_rst: assert property (p_rst) else $error("reset oe");
  property p_drv; (pin_out & ~pin_oe) == '0; endproperty
  a_drv: assert property (p_drv) else $error("input driven");
  property p_oe; $changed(pin_oe) |-> $past(hwrite, 2) || $past(hwrite, 3); endproperty
  a_oe: assert property (p_oe) else $error("oe moved");
  property p_up; rd && hit |=> hrdata[31:9] == UPPER_READ; endproperty
  a_up: assert property (p_up) else $error("upper");
  property p_miss; rd && !hit |=> hrdata == 32'h0; endproperty
  a_miss: assert property (p_miss) else $error("miss");
endmodule
bind general_purpose_pin_port pin_port_checker chk (.*);

// ==== pin_port_pkg.sv ====
package pin_port_pkg;
  localparam int unsigned NUM_PINS = 8;
  localparam logic [31:0] PIN_PORT_REGISTER_OFFSET = 32'h0000_0060;
  localparam int unsigned SELECT_BIT = 8;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic SELECT_RESET = 1'b0;
  localparam logic [22:0] UPPER_READ = 23'h7FFFFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

// ==== pin_sync.sv ====
module pin_sync
  import pin_port_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_s;

  sync_s q_r;
  sync_s q_nxt;

  // Stage one feeds only stage two; accept a change once stages two and three agree
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = async_in;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q_r.s2[i] == q_r.s3[i]) begin
        q_nxt.lvl[i] = q_r.s3[i];
      end
    end
  end

  // Constant reset; no port value captured
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign level = q_r.lvl;
endmodule
